// ---- core/e3_tx_line.sv ----
// E3 transmit overhead insertion and line output with APB registers
`timescale 1ns/1ps
module e3_tx_line (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic LINE_CLOCK_IN,
  input wire logic PAYLOAD_DATA,
  input wire logic OH_ALARM_BIT,
  input wire logic OH_NATIONAL_BIT,
  input wire logic RX_BIT,
  input wire logic RX_BIT_VALID,
  input wire logic RX_FRAME_START,
  output logic PAYLOAD_REQ,
  output logic POS_RAIL_OUT,
  output logic NEG_RAIL_OUT,
  output logic LINE_CLOCK_OUT,
  output logic RX_PARITY_ERROR,
  output logic RX_UNIPOLAR_MODE,
  output logic RX_AMI_MODE
);

  // Reset release synchroniser
  logic rst_meta;
  logic rst_n;

  // Async assert, two flop release
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Line clock synchroniser and edge history
  logic lclk_meta;
  logic lclk_sync;
  logic lclk_prev;
  // One bit period passes per rising line clock edge
  wire tick = lclk_sync && !lclk_prev;

  // First flop feeds only the second
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      lclk_meta <= 1'b0;
      lclk_sync <= 1'b0;
      lclk_prev <= 1'b0;
    end else begin
      lclk_meta <= LINE_CLOCK_IN;
      lclk_sync <= lclk_meta;
      lclk_prev <= lclk_sync;
    end
  end

  // Registers
  logic [7:0] line_io_control;
  logic [7:0] tx_frame_config;
  logic [7:0] service_bits;
  logic [4:0] align_err_mask_hi;
  logic [4:0] align_err_mask_lo;
  logic [3:0] parity_err_mask;
  // Clock loss state
  logic [7:0] idle_count;
  logic clock_loss_flag;

  // Field views
  wire tx_clock_loss_disable = line_io_control[e3_tx_pkg::IO_TX_LOSS_DIS];
  wire line_code_sel = line_io_control[e3_tx_pkg::IO_CODE_SEL];
  wire unipolar = line_io_control[e3_tx_pkg::IO_UNIPOLAR];
  wire tx_clock_edge_invert = line_io_control[e3_tx_pkg::IO_TX_INV];
  wire parity_nibble_enable = tx_frame_config[e3_tx_pkg::CFG_PAR_EN];
  wire [1:0] alarm_bit_source_sel = {tx_frame_config[e3_tx_pkg::CFG_ALARM_HI],
                                     tx_frame_config[e3_tx_pkg::CFG_ALARM_LO]};
  wire [1:0] national_bit_source_sel = {tx_frame_config[e3_tx_pkg::CFG_NAT_HI],
                                        tx_frame_config[e3_tx_pkg::CFG_NAT_LO]};
  wire alarm_ones_enable = tx_frame_config[e3_tx_pkg::CFG_AIS];
  wire signal_loss_pattern_enable = tx_frame_config[e3_tx_pkg::CFG_LOS];

  // Address match on a word address
  function automatic logic hit(input logic [11:0] addr,
                               input logic [11:0] base);
    hit = addr == base;
  endfunction

  // Address decode
  wire sel_io = hit(PADDR, e3_tx_pkg::ADDR_LINE_IO);
  wire sel_cfg = hit(PADDR, e3_tx_pkg::ADDR_TX_CFG);
  wire sel_svc = hit(PADDR, e3_tx_pkg::ADDR_SERVICE);
  wire sel_hi = hit(PADDR, e3_tx_pkg::ADDR_MASK_HI);
  wire sel_lo = hit(PADDR, e3_tx_pkg::ADDR_MASK_LO);
  wire sel_pm = hit(PADDR, e3_tx_pkg::ADDR_PAR_MASK);
  wire mapped = sel_io || sel_cfg || sel_svc || sel_hi || sel_lo || sel_pm;
  // Setup phase; answer is prepared here
  wire setup = PSEL && !PENABLE;
  // Write lands only at the completing access edge
  wire wr = PSEL && PENABLE && PWRITE && PREADY && mapped;

  // Live loss flag shown in bit 6
  wire [7:0] io_view = {line_io_control[7], clock_loss_flag,
                        line_io_control[5:0]};
  wire [7:0] rd_byte =
    sel_io ? io_view :
    sel_cfg ? tx_frame_config :
    sel_svc ? service_bits :
    sel_hi ? {3'b000, align_err_mask_hi} :
    sel_lo ? {3'b000, align_err_mask_lo} :
    sel_pm ? {4'h0, parity_err_mask} :
    8'h00;

  // Bus answer registered in setup, valid during access
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= setup;
      if (setup) begin
        // Reads past the low byte see zero
        PRDATA <= PWRITE ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        // Unmapped words answer with an error, no effect
        PSLVERR <= !mapped;
      end
    end
  end

  // Register writes; loss flag bit is not writable
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      line_io_control <= e3_tx_pkg::RST_LINE_IO;
      tx_frame_config <= e3_tx_pkg::RST_TX_CFG;
      service_bits <= e3_tx_pkg::RST_SERVICE;
      align_err_mask_hi <= e3_tx_pkg::RST_ALIGN_MASK;
      align_err_mask_lo <= e3_tx_pkg::RST_ALIGN_MASK;
      parity_err_mask <= e3_tx_pkg::RST_PAR_MASK;
    end else if (wr) begin
      if (sel_io) begin
        line_io_control <= {PWDATA[7], 1'b0, PWDATA[5:0]};
      end else if (sel_cfg) begin
        tx_frame_config <= PWDATA[7:0];
      end else if (sel_svc) begin
        // Only the two service bits are kept
        service_bits <= {6'h00, PWDATA[1:0]};
      end else if (sel_hi) begin
        align_err_mask_hi <= PWDATA[4:0];
      end else if (sel_lo) begin
        align_err_mask_lo <= PWDATA[4:0];
      end else if (sel_pm) begin
        parity_err_mask <= PWDATA[3:0];
      end
    end
  end

  // Loss of line clock: no edge for the loss time
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      idle_count <= 8'h00;
      clock_loss_flag <= 1'b0;
    end else begin
      if (tick) begin
        idle_count <= 8'h00;
      end else if (idle_count != e3_tx_pkg::LOSS_CYCLES) begin
        idle_count <= idle_count + 8'h01;
      end
      // Masked while disabled; clears on the next edge
      clock_loss_flag <= !tx_clock_loss_disable && !tick &&
                         idle_count == e3_tx_pkg::LOSS_CYCLES;
    end
  end

  // Transmit frame position, zero based
  logic [10:0] frame_pos;
  // Parity accumulating over the frame in flight
  logic [3:0] par_acc;
  // Parity of the previous frame, inserted now
  logic [3:0] par_last;
  // Receive side parity state
  logic [10:0] rx_pos;
  logic [3:0] rx_acc;
  logic [3:0] rx_last;
  logic rx_bad;
  // Last receive frame held a parity error
  logic rx_err_seen;

  // Slot decode
  wire in_fas = frame_pos <= e3_tx_pkg::POS_FAS_LAST;
  wire in_par = frame_pos >= e3_tx_pkg::POS_PAR_FIRST;
  wire is_alarm = frame_pos == e3_tx_pkg::POS_ALARM;
  wire is_nat = frame_pos == e3_tx_pkg::POS_NAT;
  // Lane of the nibble, first nibble bit is lane 3
  wire [1:0] lane = ~frame_pos[1:0];
  wire [3:0] fas_idx = 4'(e3_tx_pkg::POS_FAS_LAST - frame_pos);
  // Alignment pattern with both masks applied
  wire [9:0] fas_out = e3_tx_pkg::FAS_PATTERN ^
                       {align_err_mask_hi, align_err_mask_lo};
  // Mask applies only where the nibble is inserted
  wire [3:0] par_out = par_last ^ parity_err_mask;
  wire par_slot = in_par && parity_nibble_enable;

  // A bit by source select
  wire alarm_bit =
    alarm_bit_source_sel == e3_tx_pkg::SRC_REG ?
      service_bits[e3_tx_pkg::SVC_ALARM] :
    alarm_bit_source_sel == e3_tx_pkg::SRC_OH ? OH_ALARM_BIT :
    alarm_bit_source_sel == e3_tx_pkg::SRC_PAYLOAD ? PAYLOAD_DATA :
    rx_err_seen;
  // N bit by source select; the last code falls back on the register
  wire nat_bit =
    national_bit_source_sel == e3_tx_pkg::SRC_OH ? OH_NATIONAL_BIT :
    national_bit_source_sel == e3_tx_pkg::SRC_PAYLOAD ? PAYLOAD_DATA :
    service_bits[e3_tx_pkg::SVC_NAT];

  // Payload consumed in payload slots and payload sourced overhead
  wire take_payload = (!in_fas && !is_alarm && !is_nat && !par_slot) ||
    (is_alarm && alarm_bit_source_sel == e3_tx_pkg::SRC_PAYLOAD) ||
    (is_nat && national_bit_source_sel == e3_tx_pkg::SRC_PAYLOAD);

  // Framed bit before alarm overrides
  wire framed_bit =
    in_fas ? fas_out[fas_idx] :
    is_alarm ? alarm_bit :
    is_nat ? nat_bit :
    par_slot ? par_out[lane] :
    PAYLOAD_DATA;
  // Loss pattern beats everything; AIS sends unframed ones
  wire frame_bit = signal_loss_pattern_enable ? 1'b0 :
                   alarm_ones_enable ? 1'b1 : framed_bit;

  // Parity sum including the bit sent now
  wire [3:0] lane_bit = 4'(frame_bit) << lane;
  wire [3:0] next_par_acc = par_acc ^ lane_bit;
  wire frame_end = frame_pos == e3_tx_pkg::FRAME_LAST;

  // Frame position and transmit parity
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      frame_pos <= 11'h000;
      par_acc <= 4'h0;
      par_last <= 4'h0;
    end else if (tick) begin
      if (frame_end) begin
        frame_pos <= 11'h000;
        par_acc <= 4'h0;
        // Saved for the closing nibble of the next frame
        par_last <= next_par_acc;
      end else begin
        frame_pos <= frame_pos + 11'h001;
        par_acc <= next_par_acc;
      end
    end
  end

  // Payload strobe marks the tick that sampled the data
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      PAYLOAD_REQ <= 1'b0;
    end else begin
      PAYLOAD_REQ <= tick && take_payload;
    end
  end

  // Bit handed to the encoder with its frame marker
  e3_tx_pkg::line_bit_t enc_in;
  e3_tx_pkg::rail_t rail;
  assign enc_in.data = frame_bit;
  assign enc_in.frame_start = frame_pos == 11'h000;

  // Rail encoder, four bit periods of latency in every mode
  line_encoder u_encoder (
    .clk(CLOCK),
    .rst_n(rst_n),
    .tick(tick),
    .unipolar(unipolar),
    .ami(line_code_sel),
    .bit_in(enc_in),
    .rail(rail)
  );
  assign POS_RAIL_OUT = rail.pos;
  assign NEG_RAIL_OUT = rail.neg;

  // Line clock toward the line unit; the plain output puts data
  // changes on its rising edge so the unit samples mid bit
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      LINE_CLOCK_OUT <= 1'b0;
    end else begin
      LINE_CLOCK_OUT <= lclk_sync ^ tx_clock_edge_invert;
    end
  end

  // Receive side checking
  wire rx_in_par = rx_pos >= e3_tx_pkg::POS_PAR_FIRST;
  wire [1:0] rx_lane = ~rx_pos[1:0];
  wire [3:0] rx_lane_bit = 4'(RX_BIT) << rx_lane;
  // Mismatch of this bit against the expected nibble
  wire rx_miss = rx_in_par && (RX_BIT != rx_last[rx_lane]);
  wire rx_end = rx_pos == e3_tx_pkg::FRAME_LAST;

  // Receive position, parity sum and compare
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      rx_pos <= 11'h000;
      rx_acc <= 4'h0;
      rx_last <= 4'h0;
      rx_bad <= 1'b0;
      rx_err_seen <= 1'b0;
      RX_PARITY_ERROR <= 1'b0;
    end else begin
      RX_PARITY_ERROR <= 1'b0;
      if (RX_BIT_VALID) begin
        if (RX_FRAME_START) begin
          // A start bit realigns the count at position one
          rx_pos <= 11'h001;
          // Lane 3, not the stale count of a misaligned frame
          rx_acc <= {RX_BIT, 3'h0};
          rx_bad <= 1'b0;
        end else if (rx_end) begin
          rx_pos <= 11'h000;
          rx_acc <= 4'h0;
          rx_last <= rx_acc ^ rx_lane_bit;
          rx_bad <= 1'b0;
          if (parity_nibble_enable) begin
            RX_PARITY_ERROR <= rx_bad || rx_miss;
            rx_err_seen <= rx_bad || rx_miss;
          end
        end else begin
          rx_pos <= rx_pos + 11'h001;
          rx_acc <= rx_acc ^ rx_lane_bit;
          rx_bad <= rx_bad || rx_miss;
        end
      end
    end
  end

  // Coding choice also steers the receive line interface
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      RX_UNIPOLAR_MODE <= 1'b0;
      RX_AMI_MODE <= 1'b0;
    end else begin
      RX_UNIPOLAR_MODE <= unipolar;
      RX_AMI_MODE <= line_code_sel;
    end
  end

endmodule // e3_tx_line

// ---- core/e3_tx_pkg.sv ----
// Shared constants and carrier types of the E3 transmit line block
package e3_tx_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_LINE_IO = 8'h01;
  localparam logic [7:0] IDX_TX_CFG = 8'h30;
  localparam logic [7:0] IDX_SERVICE = 8'h35;
  localparam logic [7:0] IDX_MASK_HI = 8'h48;
  localparam logic [7:0] IDX_MASK_LO = 8'h49;
  localparam logic [7:0] IDX_PAR_MASK = 8'h4a;
  localparam logic [11:0] ADDR_LINE_IO = {2'b00, IDX_LINE_IO, 2'b00};
  localparam logic [11:0] ADDR_TX_CFG = {2'b00, IDX_TX_CFG, 2'b00};
  localparam logic [11:0] ADDR_SERVICE = {2'b00, IDX_SERVICE, 2'b00};
  localparam logic [11:0] ADDR_MASK_HI = {2'b00, IDX_MASK_HI, 2'b00};
  localparam logic [11:0] ADDR_MASK_LO = {2'b00, IDX_MASK_LO, 2'b00};
  localparam logic [11:0] ADDR_PAR_MASK = {2'b00, IDX_PAR_MASK, 2'b00};

  // Reset values
  localparam logic [7:0] RST_LINE_IO = 8'ha0;
  localparam logic [7:0] RST_TX_CFG = 8'h00;
  localparam logic [7:0] RST_SERVICE = 8'h02;
  localparam logic [4:0] RST_ALIGN_MASK = 5'h00;
  localparam logic [3:0] RST_PAR_MASK = 4'h0;

  // Field positions, line io control
  localparam int IO_TX_LOSS_DIS = 7;
  localparam int IO_LOSS_FLAG = 6;
  localparam int IO_RX_LOSS_DIS = 5;
  localparam int IO_CODE_SEL = 4;
  localparam int IO_UNIPOLAR = 3;
  localparam int IO_TX_INV = 2;
  // Field positions, transmit frame config
  localparam int CFG_PAR_EN = 7;
  localparam int CFG_ALARM_HI = 6;
  localparam int CFG_ALARM_LO = 5;
  localparam int CFG_NAT_HI = 4;
  localparam int CFG_NAT_LO = 3;
  localparam int CFG_AIS = 2;
  localparam int CFG_LOS = 1;
  // Field positions, service bits
  localparam int SVC_ALARM = 1;
  localparam int SVC_NAT = 0;

  // Frame layout, zero based bit positions
  localparam logic [10:0] FRAME_LAST = 11'h5ff;
  localparam logic [10:0] POS_ALARM = 11'h00a;
  localparam logic [10:0] POS_NAT = 11'h00b;
  localparam logic [10:0] POS_PAR_FIRST = 11'h5fc;
  localparam logic [10:0] POS_FAS_LAST = 11'h009;
  localparam logic [9:0] FAS_PATTERN = 10'h3d0;

  // Source select codes
  localparam logic [1:0] SRC_REG = 2'h0;
  localparam logic [1:0] SRC_OH = 2'h1;
  localparam logic [1:0] SRC_PAYLOAD = 2'h2;

  // Line encoder slot kinds
  localparam logic [1:0] K_SPACE = 2'h0;
  localparam logic [1:0] K_MARK = 2'h1;
  localparam logic [1:0] K_VIOL = 2'h2;

  // Loss of line clock detection
  localparam int CLK_PERIOD_NS = 25;
  localparam int LOSS_TIME_NS = 1000;
  localparam logic [7:0] LOSS_CYCLES =
    8'((LOSS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // One outbound bit with its frame marker
  typedef struct packed {
    logic data;
    logic frame_start;
  } line_bit_t;

  // The two rail levels toward the line unit
  typedef struct packed {
    logic pos;
    logic neg;
  } rail_t;

endpackage

// ---- core/line_encoder.sv ----
// Unipolar, AMI and HDB3 rail encoder with four bit lookahead
`timescale 1ns/1ps
module line_encoder (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic unipolar,
  input wire logic ami,
  input wire e3_tx_pkg::line_bit_t bit_in,
  output e3_tx_pkg::rail_t rail
);

  // Four slots of kinds, oldest in the top two bits
  logic [7:0] kinds;
  // Frame markers travel beside the data
  logic [3:0] starts;
  // Polarity of the last pulse sent, high when positive
  logic last_pos;
  // Odd count of B pulses since the last violation
  logic vpar;

  wire [1:0] out_kind = kinds[7:6];
  wire out_mark = out_kind == e3_tx_pkg::K_MARK;
  wire out_viol = out_kind == e3_tx_pkg::K_VIOL;
  wire [1:0] in_kind = bit_in.data ? e3_tx_pkg::K_MARK : e3_tx_pkg::K_SPACE;
  wire [7:0] shifted = {kinds[5:0], in_kind};
  // Parity after the pulse leaving now is counted
  wire odd_now = out_viol ? 1'b0 : (vpar ^ out_mark);
  // A window of four spaces under HDB3 gets replaced
  wire sub_needed = !ami && !unipolar && shifted == 8'h00;
  // Odd count takes 000V, even count takes B00V
  wire [1:0] head_kind = odd_now ? e3_tx_pkg::K_SPACE : e3_tx_pkg::K_MARK;
  wire [7:0] sub_kinds = {head_kind, e3_tx_pkg::K_SPACE,
                          e3_tx_pkg::K_SPACE, e3_tx_pkg::K_VIOL};
  wire [7:0] next_kinds = sub_needed ? sub_kinds : shifted;
  // Marks alternate, violations repeat the last polarity
  wire pulse_pos = out_mark ? !last_pos : last_pos;
  wire pulse = out_mark || out_viol;

  // Slot pipeline; the frame marker keeps pace with its bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      kinds <= 8'h00;
      starts <= 4'h0;
    end else if (tick) begin
      kinds <= next_kinds;
      starts <= {starts[2:0], bit_in.frame_start};
    end
  end

  // Polarity and parity state; defined after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_pos <= 1'b0;
      vpar <= 1'b0;
    end else if (tick && !unipolar) begin
      if (out_mark) begin
        last_pos <= pulse_pos;
      end
      vpar <= odd_now;
    end
  end

  // Rail outputs, one update per bit period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rail <= '0;
    end else if (tick) begin
      if (unipolar) begin
        rail.pos <= out_kind != e3_tx_pkg::K_SPACE;
        rail.neg <= starts[3];
      end else begin
        rail.pos <= pulse && pulse_pos;
        rail.neg <= pulse && !pulse_pos;
      end
    end
  end

endmodule // line_encoder

// ---- dv/e3_tx_line_bench.sv ----
// Self-checking bench for the E3 transmit line block
`timescale 1ns/1ps
module e3_tx_line_bench;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic PAYLOAD_DATA = 1'b0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, PAYLOAD_REQ, POS_RAIL_OUT, NEG_RAIL_OUT;
  logic LINE_CLOCK_OUT, RX_PARITY_ERROR, RX_UNIPOLAR_MODE, RX_AMI_MODE;
  logic LINE_CLOCK_IN, RX_BIT, RX_BIT_VALID, RX_FRAME_START;
  e3_tx_pkg::rail_t rail;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  int perr = 0;
  // Payload runs four zeros, four ones while enabled
  logic pay_on = 1'b1;
  logic [2:0] pcnt = 3'h0;
  logic fr [0:3071];
  logic [31:0] q;
  logic e;
  logic [9:0] v;
  logic [3:0] par;
  assign rail = {POS_RAIL_OUT, NEG_RAIL_OUT};
  always #12.5 CLOCK = ~CLOCK;
  e3_tx_line u_dut (
    .CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .LINE_CLOCK_IN(LINE_CLOCK_IN),
    .PAYLOAD_DATA(PAYLOAD_DATA), .OH_ALARM_BIT(1'b0),
    .OH_NATIONAL_BIT(1'b0), .RX_BIT(RX_BIT), .RX_BIT_VALID(RX_BIT_VALID),
    .RX_FRAME_START(RX_FRAME_START), .PAYLOAD_REQ(PAYLOAD_REQ),
    .POS_RAIL_OUT(POS_RAIL_OUT), .NEG_RAIL_OUT(NEG_RAIL_OUT),
    .LINE_CLOCK_OUT(LINE_CLOCK_OUT), .RX_PARITY_ERROR(RX_PARITY_ERROR),
    .RX_UNIPOLAR_MODE(RX_UNIPOLAR_MODE), .RX_AMI_MODE(RX_AMI_MODE)
  );
  liu_model u_liu (
    .clk(CLOCK), .line_clock_out(LINE_CLOCK_OUT), .rail(rail),
    .line_clock_in(LINE_CLOCK_IN), .rx_bit(RX_BIT),
    .rx_bit_valid(RX_BIT_VALID), .rx_frame_start(RX_FRAME_START)
  );
  task report_and_stop;
    if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One APB transfer; held until ready is seen at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    // Only the hang guard ends a wait that never completes
    do begin
      @(posedge CLOCK);
    end while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task rd(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, exp, q);
  endtask
  // Collects n looped back bits, starting at a frame marker
  task grab(input int n);
    int i;
    i = 0;
    while (i < n) begin
      @(posedge CLOCK);
      if (RX_BIT_VALID === 1'b1 && (i > 0 || RX_FRAME_START === 1'b1)) begin
        fr[i] = RX_BIT;
        i++;
      end
    end
  endtask
  task fas_chk(input logic a);
    for (int i = 0; i < 10; i++) v[9 - i] = fr[i];
    chk("fas", 32'(e3_tx_pkg::FAS_PATTERN ^ 10'h3e3), 32'(v));
    chk("alarm", 32'(a), 32'(fr[10]));
  endtask
  // Payload feed and parity error count
  always @(posedge CLOCK) begin
    if (PAYLOAD_REQ === 1'b1) begin
      pcnt <= pcnt + 3'h1;
      PAYLOAD_DATA <= pay_on & pcnt[2];
    end
    if (RX_PARITY_ERROR === 1'b1) perr++;
  end
  // Hang guard, well above the longest path of the sequence
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 100000) begin
      n_fail++;
      report_and_stop;
    end
  end
  initial begin
    repeat (16) @(posedge CLOCK);
    RST_N <= 1'b1;
    repeat (2) @(posedge CLOCK);
    rd("io", e3_tx_pkg::ADDR_LINE_IO, 32'h0000_00a0);
    rd("cfg", e3_tx_pkg::ADDR_TX_CFG, 32'h0000_0000);
    rd("svc", e3_tx_pkg::ADDR_SERVICE, 32'h0000_0002);
    rd("mhi", e3_tx_pkg::ADDR_MASK_HI, 32'h0000_0000);
    rd("mlo", e3_tx_pkg::ADDR_MASK_LO, 32'h0000_0000);
    rd("pmask", e3_tx_pkg::ADDR_PAR_MASK, 32'h0000_0000);
    apb(1'b1, e3_tx_pkg::ADDR_LINE_IO, 32'h0000_00e0);
    rd("io flag", e3_tx_pkg::ADDR_LINE_IO, 32'h0000_00a0);
    rd("unmapped", 12'hffc, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, 32'(e));
    // HDB3, then AMI, watched by the checker
    repeat (2000) @(posedge CLOCK);
    apb(1'b1, e3_tx_pkg::ADDR_LINE_IO, 32'h0000_00b0);
    repeat (2000) @(posedge CLOCK);
    pay_on <= 1'b0;
    apb(1'b1, e3_tx_pkg::ADDR_MASK_HI, 32'hffff_ffff);
    rd("mhi", e3_tx_pkg::ADDR_MASK_HI, 32'h0000_001f);
    apb(1'b1, e3_tx_pkg::ADDR_MASK_LO, 32'h0000_0003);
    rd("mlo", e3_tx_pkg::ADDR_MASK_LO, 32'h0000_0003);
    apb(1'b1, e3_tx_pkg::ADDR_PAR_MASK, 32'h0000_0005);
    rd("pmask", e3_tx_pkg::ADDR_PAR_MASK, 32'h0000_0005);
    apb(1'b1, e3_tx_pkg::ADDR_LINE_IO, 32'h0000_00a8);
    // A late bipolar negative pulse must not pass for a frame marker
    repeat (24) @(posedge CLOCK);
    grab(1536);
    fas_chk(1'b1);
    chk("nibble", 32'h0, 32'({fr[1532], fr[1533], fr[1534], fr[1535]}));
    chk("rx off", 32'h0, 32'(perr));
    apb(1'b1, e3_tx_pkg::ADDR_SERVICE, 32'h0000_0000);
    apb(1'b1, e3_tx_pkg::ADDR_TX_CFG, 32'h0000_0080);
    grab(3072);
    fas_chk(1'b0);
    par = 4'h0;
    for (int i = 0; i < 1536; i++) par[3 - i % 4] ^= fr[i];
    chk("parity", 32'(par ^ 4'h5),
      32'({fr[3068], fr[3069], fr[3070], fr[3071]}));
    repeat (4) @(posedge CLOCK);
    chk("rx error", 32'h1, 32'(perr != 0));
    report_and_stop;
  end
endmodule // e3_tx_line_bench

// ---- dv/e3_tx_line_sva.sv ----
// Assertion checker for the E3 transmit line block
`timescale 1ns/1ps
module e3_tx_line_sva (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic POS_RAIL_OUT,
  input wire logic NEG_RAIL_OUT,
  input wire logic RX_UNIPOLAR_MODE,
  input wire logic RX_AMI_MODE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // Cycles since the line mode changed; old slots drain first
  logic [6:0] settle;
  // Cycles with both rails quiet
  logic [5:0] quiet;
  // Polarity of the last pulse seen
  logic last_pos;
  // Mode pair one cycle ago
  logic [1:0] mode_q;
  wire logic [1:0] mode = {RX_UNIPOLAR_MODE, RX_AMI_MODE};
  wire logic steady = settle == 7'h7f;
  // Helper counters, cleared by reset
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      settle <= 7'h00;
      quiet <= 6'h00;
      last_pos <= 1'b0;
      mode_q <= 2'h0;
    end else begin
      mode_q <= mode;
      settle <= (mode != mode_q) ? 7'h00 : settle + {6'h00, !steady};
      quiet <= (POS_RAIL_OUT || NEG_RAIL_OUT) ? 6'h00 :
        quiet + {5'h00, quiet != 6'h3f};
      if ($rose(POS_RAIL_OUT) || $rose(NEG_RAIL_OUT)) begin
        last_pos <= POS_RAIL_OUT;
      end
    end
  end
  sequence s_io_write;
    PSEL && PENABLE && PREADY && PWRITE && PADDR == e3_tx_pkg::ADDR_LINE_IO;
  endsequence
  sequence s_marker;
    NEG_RAIL_OUT [*6] ##[1:4] !NEG_RAIL_OUT;
  endsequence
  a_ready_first:
    assert property (PSEL && !PENABLE |=> PREADY)
    else $error("ready missing in first access cycle");
  a_ready_single:
    assert property (PREADY |=> !PREADY)
    else $error("ready held two cycles");
  a_mask_upper_zero:
    assert property (PREADY && !PWRITE && (PADDR == e3_tx_pkg::ADDR_MASK_HI
      || PADDR == e3_tx_pkg::ADDR_MASK_LO) |-> PRDATA[31:5] == 27'h000_0000)
    else $error("alignment mask upper bits not zero");
  a_mode_copy:
    assert property (s_io_write |-> ##2 RX_UNIPOLAR_MODE == $past(PWDATA[3], 2)
      && RX_AMI_MODE == $past(PWDATA[4], 2))
    else $error("line mode outputs do not follow register");
  a_uni_marker:
    assert property ($rose(NEG_RAIL_OUT) && RX_UNIPOLAR_MODE && steady
      |-> s_marker)
    else $error("frame marker not one bit period long");
  a_rails_apart:
    assert property (!RX_UNIPOLAR_MODE && steady
      |-> !(POS_RAIL_OUT && NEG_RAIL_OUT))
    else $error("both rails high in bipolar mode");
  a_ami_alternate:
    assert property (RX_AMI_MODE && !RX_UNIPOLAR_MODE && steady &&
      ($rose(POS_RAIL_OUT) || $rose(NEG_RAIL_OUT)) |-> POS_RAIL_OUT != last_pos)
    else $error("mark polarity did not alternate");
  a_hdb3_no_run:
    assert property (!RX_AMI_MODE && !RX_UNIPOLAR_MODE && steady
      |-> quiet < 6'h1c)
    else $error("four zeros sent without substitution");
endmodule // e3_tx_line_sva
bind e3_tx_line e3_tx_line_sva u_sva (
  .CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .POS_RAIL_OUT(POS_RAIL_OUT), .NEG_RAIL_OUT(NEG_RAIL_OUT),
  .RX_UNIPOLAR_MODE(RX_UNIPOLAR_MODE), .RX_AMI_MODE(RX_AMI_MODE)
);

// ---- dv/liu_model.sv ----
// Line unit model: bit clock source and rail sampler with loopback
`timescale 1ns/1ps
module liu_model (
  input wire logic clk,
  input wire logic line_clock_out,
  input wire e3_tx_pkg::rail_t rail,
  output logic line_clock_in,
  output logic rx_bit,
  output logic rx_bit_valid,
  output logic rx_frame_start
);
  // Returned line clock one cycle ago
  logic lco_q;
  // Free running bit clock, phase offset from clk
  initial begin
    line_clock_in = 1'b0;
    rx_bit = 1'b0;
    rx_bit_valid = 1'b0;
    rx_frame_start = 1'b0;
    lco_q = 1'b0;
    #3;
    forever #100 line_clock_in = ~line_clock_in;
  end
  // Sample mid bit, on the falling edge, away from rail updates
  always @(posedge clk) begin
    lco_q <= line_clock_out;
    rx_bit_valid <= lco_q && !line_clock_out;
    rx_bit <= rail.pos;
    rx_frame_start <= rail.neg;
  end
endmodule // liu_model
